// [design/mrb_bank.sv]
// Mode-register bank: mode register write/read decode, calibration, masks
`timescale 1ns/10ps
module mrb_bank #(
  parameter logic [7:0] REV_ONE   = 8'h01, // Arbitrary value
  parameter logic [7:0] REV_TWO   = 8'h00, // Arbitrary value
  parameter logic [1:0] IO_WIDTH  = 2'h0,
  parameter logic [7:0] PATTERN_A = 8'hA5
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire mrb_pkg::mrb_req_t req,
  input  wire logic             rzqPin,
  input  wire logic             powerDown,
  input  wire logic [12:0]      refreshRow,
  input  wire logic [2:0]       refreshBank,
  output logic [7:0]            rdData,
  output logic                  rdValid,
  output logic [1:0]            termSelect,
  output logic                  termActive,
  output logic [7:0]            bankMask,
  output logic [7:0]            segmentMask,
  output logic                  refreshBlocked,
  output mrb_pkg::mrb_cal_t     calStart
);
  // ************************************************************
  // Pin synchroniser for resistor detect
  // ************************************************************
  logic [2:0] rzqSync;
  logic       rzqFitted;
  logic [7:0] termCtl;
  logic [7:0] baseInfo;
  logic [7:0] next_termCtl;
  logic [7:0] next_bankMask;
  logic [7:0] next_segmentMask;
  logic [7:0] next_baseInfo;
  logic [7:0] next_rdData;
  logic       next_rdValid;
  logic [1:0] next_termSelect;
  logic       next_termActive;
  logic       next_refreshBlocked;
  logic       next_rzqFitted;
  mrb_pkg::mrb_cal_t next_calStart;
  logic [2:0] segIdx;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rzqSync <= 3'h0;
    end else begin
      rzqSync <= {rzqSync[1:0], rzqPin};
    end
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    next_termCtl     = termCtl;
    next_bankMask    = bankMask;
    next_segmentMask = segmentMask;
    next_baseInfo    = baseInfo;
    next_calStart    = mrb_pkg::CAL_NONE;
    next_rdValid     = req.rdEn;
    next_rdData      = 8'h00;
    next_rzqFitted   = (rzqSync[2] == rzqSync[1]) ? rzqSync[2] : rzqFitted;
    segIdx           = refreshRow[mrb_pkg::SEG_ROW_LSB +: 3];
    if (req.wrEn) begin
      case (req.addr)
        mrb_pkg::ADDR_CALIBRATION_COMMAND: begin
          if (rzqFitted) begin
            case (req.data)
              mrb_pkg::CAL_INIT: begin
                next_calStart = mrb_pkg::CAL_DO_INIT;
                next_baseInfo[mrb_pkg::BASE_RZQ_BIT] = 1'b1;
              end
              mrb_pkg::CAL_LONG:  next_calStart = mrb_pkg::CAL_DO_LONG;
              mrb_pkg::CAL_SHORT: next_calStart = mrb_pkg::CAL_DO_SHORT;
              mrb_pkg::CAL_RESET: next_calStart = mrb_pkg::CAL_DO_RESET;
              default:            next_calStart = mrb_pkg::CAL_NONE;
            endcase
          end else if (req.data == mrb_pkg::CAL_INIT) begin
            next_baseInfo[mrb_pkg::BASE_RZQ_BIT] = 1'b0;
          end
        end
        mrb_pkg::ADDR_TERMINATION_CONTROL:  next_termCtl     = req.data;
        mrb_pkg::ADDR_REFRESH_BANK_MASK:    next_bankMask    = req.data;
        mrb_pkg::ADDR_REFRESH_SEGMENT_MASK: next_segmentMask = req.data;
        default: ; // Read-only and reserved addresses hold state
      endcase
    end
    if (req.rdEn) begin
      case (req.addr)
        mrb_pkg::ADDR_BASE_DEVICE_INFO:      next_rdData = baseInfo;
        mrb_pkg::ADDR_REVISION_CODE_ONE:     next_rdData = REV_ONE;
        mrb_pkg::ADDR_REVISION_CODE_TWO:     next_rdData = REV_TWO;
        mrb_pkg::ADDR_DEVICE_INFORMATION:
          next_rdData = {IO_WIDTH, mrb_pkg::INFO_DENSITY, mrb_pkg::INFO_TYPE};
        mrb_pkg::ADDR_CALIBRATION_PATTERN_A: next_rdData = PATTERN_A;
        default:                             next_rdData = 8'h00;
      endcase
    end
    next_termSelect = next_termCtl[mrb_pkg::TERM_SEL_LSB +: 2];
    next_termActive = (next_termSelect != 2'h0)
                      && (!powerDown || next_termCtl[mrb_pkg::TERM_PD_BIT]);
    next_refreshBlocked = next_bankMask[refreshBank]
                          || next_segmentMask[segIdx];
  end

  // ************************************************************
  // State registers
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      termCtl        <= mrb_pkg::RST_TERM_CONTROL;
      bankMask       <= mrb_pkg::RST_BANK_MASK;
      segmentMask    <= mrb_pkg::RST_SEGMENT_MASK;
      baseInfo       <= mrb_pkg::RST_BASE_INFO;
      rdData         <= 8'h00;
      rdValid        <= 1'b0;
      termSelect     <= 2'h0;
      termActive     <= 1'b0;
      refreshBlocked <= 1'b0;
      rzqFitted      <= 1'b0;
      calStart       <= mrb_pkg::CAL_NONE;
    end else begin
      termCtl        <= next_termCtl;
      bankMask       <= next_bankMask;
      segmentMask    <= next_segmentMask;
      baseInfo       <= next_baseInfo;
      rdData         <= next_rdData;
      rdValid        <= next_rdValid;
      termSelect     <= next_termSelect;
      termActive     <= next_termActive;
      refreshBlocked <= next_refreshBlocked;
      rzqFitted      <= next_rzqFitted;
      calStart       <= next_calStart;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_rev_read: assert property (
    req.rdEn && req.addr == mrb_pkg::ADDR_REVISION_CODE_ONE |=> rdValid && rdData == REV_ONE)
    else $error("Revision one read wrong");
  a_info_read: assert property (
    req.rdEn && req.addr == mrb_pkg::ADDR_DEVICE_INFORMATION
    |=> rdData == {IO_WIDTH, 4'h4, 2'h3})
    else $error("Device information wrong");
  a_cal_long: assert property (
    req.wrEn && req.addr == 8'h0A && req.data == 8'hAB && rzqFitted
    |=> calStart == mrb_pkg::CAL_DO_LONG)
    else $error("Long calibration not started");
  a_cal_short: assert property (
    req.wrEn && req.addr == mrb_pkg::ADDR_CALIBRATION_COMMAND
    && req.data == mrb_pkg::CAL_SHORT && rzqFitted
    |=> calStart == mrb_pkg::CAL_DO_SHORT)
    else $error("Short calibration not started");
  a_cal_reserved: assert property (
    req.wrEn && req.addr == 8'h0A && !(req.data inside {8'hFF, 8'hAB, 8'h56, 8'hC3})
    |=> calStart == mrb_pkg::CAL_NONE)
    else $error("Reserved code started calibration");
  a_cal_nopin: assert property (
    !rzqFitted |=> calStart == mrb_pkg::CAL_NONE)
    else $error("Calibration without resistor");
  a_init_info: assert property (
    req.wrEn && req.addr == 8'h0A && req.data == 8'hFF
    |=> baseInfo[0] == $past(rzqFitted))
    else $error("Base info not updated");
  a_term_pd: assert property (
    termSelect != 2'h0 && !termCtl[mrb_pkg::TERM_PD_BIT] && powerDown && !req.wrEn
    |=> !termActive)
    else $error("Termination kept during power down");
  a_term_keep: assert property (
    termSelect != 2'h0 && termCtl[mrb_pkg::TERM_PD_BIT] && !req.wrEn
    |=> termActive)
    else $error("Termination dropped while selected");
  a_term_sel: assert property (
    req.wrEn && req.addr == mrb_pkg::ADDR_TERMINATION_CONTROL
    |=> {6'h00, termSelect} == ($past(req.data) & 8'h03))
    else $error("Termination select not stored");
  a_bank_mask: assert property (
    req.wrEn && req.addr == 8'h10 |=> bankMask == $past(req.data))
    else $error("Bank mask not stored");
  a_seg_mask: assert property (
    req.wrEn && req.addr == mrb_pkg::ADDR_REFRESH_SEGMENT_MASK
    |=> segmentMask == $past(req.data))
    else $error("Segment mask not stored");
  a_pattern: assert property (
    req.rdEn && req.addr == 8'h20 |=> rdData == PATTERN_A)
    else $error("Pattern A wrong");
  a_reserved_wr: assert property (
    req.wrEn && req.addr inside {8'h09, [8'h0C:8'h0F], [8'h12:8'h1F]}
    |=> $stable(termCtl) && $stable(bankMask) && $stable(segmentMask))
    else $error("Reserved write changed state");

  // ************************************************************
  // Cover points
  // ************************************************************
  c_cal_init:  cover property (req.wrEn && req.addr == 8'h0A && req.data == 8'hFF);
  c_seg_block: cover property (refreshBlocked);
  c_pat_read:  cover property (req.rdEn && req.addr == 8'h20);
  c_term_pd:   cover property (termActive && powerDown);
  c_cal_nopin: cover property (req.wrEn && req.addr == 8'h0A && !rzqFitted);
endmodule : mrb_bank

// [design/mrb_pkg.sv]
// Package for the mode-register bank: addresses, codes, field layouts, carriers
package mrb_pkg;
  // ************************************************************
  // Mode addresses
  // ************************************************************
  localparam logic [7:0] ADDR_BASE_DEVICE_INFO       = 8'h00;
  localparam logic [7:0] ADDR_REVISION_CODE_ONE      = 8'h06;
  localparam logic [7:0] ADDR_REVISION_CODE_TWO      = 8'h07;
  localparam logic [7:0] ADDR_DEVICE_INFORMATION     = 8'h08;
  localparam logic [7:0] ADDR_CALIBRATION_COMMAND    = 8'h0A;
  localparam logic [7:0] ADDR_TERMINATION_CONTROL    = 8'h0B;
  localparam logic [7:0] ADDR_REFRESH_BANK_MASK      = 8'h10;
  localparam logic [7:0] ADDR_REFRESH_SEGMENT_MASK   = 8'h11;
  localparam logic [7:0] ADDR_CALIBRATION_PATTERN_A  = 8'h20;
  // ************************************************************
  // Calibration codes
  // ************************************************************
  localparam logic [7:0] CAL_INIT  = 8'hFF;
  localparam logic [7:0] CAL_LONG  = 8'hAB;
  localparam logic [7:0] CAL_SHORT = 8'h56;
  localparam logic [7:0] CAL_RESET = 8'hC3;
  // ************************************************************
  // Device information fields
  // ************************************************************
  localparam logic [1:0] INFO_TYPE      = 2'h3;
  localparam logic [3:0] INFO_DENSITY   = 4'h4;
  localparam logic [1:0] INFO_WIDTH_X32 = 2'h0;
  localparam logic [1:0] INFO_WIDTH_X16 = 2'h1;
  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int         TERM_SEL_LSB      = 0;
  localparam int         TERM_PD_BIT       = 2;
  localparam int         SEG_ROW_LSB       = 10;
  localparam int         BASE_RZQ_BIT      = 0;
  localparam logic [7:0] RST_TERM_CONTROL  = 8'h00;
  localparam logic [7:0] RST_BANK_MASK     = 8'h00;
  localparam logic [7:0] RST_SEGMENT_MASK  = 8'h00;
  localparam logic [7:0] RST_BASE_INFO     = 8'h00;
  // ************************************************************
  // Carriers
  // ************************************************************
  typedef enum logic [2:0] {CAL_NONE, CAL_DO_INIT, CAL_DO_LONG, CAL_DO_SHORT, CAL_DO_RESET}
    mrb_cal_t;
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] data;
  } mrb_req_t;
endpackage : mrb_pkg

// [dv/mrb_bank_bench.sv]
// Self-checking bench for the mode-register bank
`timescale 1ns/10ps
module mrb_bank_bench;
  logic              clk_sys = 1'b0;
  logic              rstn, rzqPin, powerDown, rdValid, termActive, refreshBlocked;
  logic [12:0]       refreshRow;
  logic [2:0]        refreshBank;
  logic [7:0]        rdData, bankMask, segmentMask, d, bm, sm;
  logic [1:0]        termSelect;
  mrb_pkg::mrb_req_t req;
  mrb_pkg::mrb_cal_t calStart;
  int                errors = 0;
  int                compares = 0;
  logic [7:0]        ids [4] = '{8'h06, 8'h07, 8'h08, 8'h20};
  logic [7:0]        rsv [5] = '{8'h09, 8'h0C, 8'h0F, 8'h12, 8'h1F};
  always #5 clk_sys = ~clk_sys;
  mrb_ctl_model ctl (.clk_sys(clk_sys), .req(req));
  mrb_bank uut (.clk_sys(clk_sys), .rstn(rstn), .req(req), .rzqPin(rzqPin),
    .powerDown(powerDown), .refreshRow(refreshRow), .refreshBank(refreshBank),
    .rdData(rdData), .rdValid(rdValid), .termSelect(termSelect), .termActive(termActive),
    .bankMask(bankMask), .segmentMask(segmentMask), .refreshBlocked(refreshBlocked),
    .calStart(calStart));
  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  function automatic logic [7:0] expRead(input logic [7:0] a, input logic rzq);
    case (a)
      8'h00:   return {7'h00, rzq};
      8'h06:   return 8'h01;
      8'h07:   return 8'h00;
      8'h08:   return {2'h0, 4'h4, 2'h3};
      8'h20:   return 8'hA5;
      default: return 8'h00;
    endcase
  endfunction : expRead
  function automatic logic [7:0] expCal(input int i, input logic rzq);
    mrb_pkg::mrb_cal_t c [4] = '{mrb_pkg::CAL_DO_INIT, mrb_pkg::CAL_DO_LONG,
                                 mrb_pkg::CAL_DO_SHORT, mrb_pkg::CAL_DO_RESET};
    return rzq ? 8'(c[i]) : 8'h00;
  endfunction : expCal
  task automatic rdChk(input logic [7:0] a, input logic rzq);
    ctl.issue(1'b0, a, 8'($urandom));
    chk("rdValid", {7'h00, rdValid}, 8'h01);
    chk("rdData", rdData, expRead(a, rzq));
  endtask : rdChk
  task automatic startUp(input logic rzq);
    rstn = 1'b0;
    rzqPin = rzq;
    repeat (2) @(posedge clk_sys);
    #1 rstn = 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask : startUp
  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    void'($urandom(32'h2028F0CA));
    powerDown = 1'b0;
    refreshRow = 13'h0000;
    refreshBank = 3'h0;
    startUp(1'b1);
    for (int i = 0; i < 4; i++) begin
      ctl.issue(1'b1, ids[i], 8'($urandom));
      rdChk(ids[i], 1'b1);
    end
    $display("identity reads done");
    for (int i = 0; i < 4; i++) begin
      ctl.cal(i);
      chk("calStart", 8'(calStart), expCal(i, 1'b1));
    end
    d = 8'($urandom);
    if (d inside {8'hFF, 8'hAB, 8'h56, 8'hC3}) d = 8'h00;
    ctl.issue(1'b1, 8'h0A, d);
    chk("calReserved", 8'(calStart), 8'h00);
    ctl.cal(0);
    rdChk(8'h00, 1'b1);
    $display("calibration done");
    for (int i = 0; i < 16; i++) begin
      d = {5'($urandom), 3'(i)};
      ctl.issue(1'b1, 8'h0B, d);
      chk("termSelect", {6'h00, termSelect}, {6'h00, d[1:0]});
      powerDown = i[3];
      @(posedge clk_sys);
      #1 chk("termActive", {7'h00, termActive},
        {7'h00, (d[1:0] != 2'h0) && (!i[3] || d[2])});
    end
    $display("termination done");
    bm = 8'($urandom);
    sm = 8'($urandom);
    ctl.issue(1'b1, 8'h10, bm);
    ctl.issue(1'b1, 8'h11, sm);
    for (int i = 0; i < 5; i++) ctl.issue(1'b1, rsv[i], 8'($urandom));
    chk("bankMask", bankMask, bm);
    chk("segmentMask", segmentMask, sm);
    chk("termSelect", {6'h00, termSelect}, {6'h00, d[1:0]});
    for (int i = 0; i < 24; i++) begin
      refreshBank = 3'($urandom);
      refreshRow = 13'($urandom);
      @(posedge clk_sys);
      #1 chk("refreshBlocked", {7'h00, refreshBlocked},
        {7'h00, bm[refreshBank] | sm[refreshRow[12:10]]});
    end
    $display("refresh masks done");
    startUp(1'b0);
    chk("bankMaskReset", bankMask, 8'h00);
    for (int i = 0; i < 4; i++) begin
      ctl.cal(i);
      chk("calIgnored", 8'(calStart), expCal(i, 1'b0));
    end
    rdChk(8'h00, 1'b0);
    $display("tied pin done");
    report_and_stop();
  end
endmodule : mrb_bank_bench

// [dv/mrb_ctl_model.sv]
// Controller model issuing mode register writes and reads
`timescale 1ns/10ps
module mrb_ctl_model (
  input  wire logic         clk_sys,
  output mrb_pkg::mrb_req_t req
);
  initial req = '0;
  // One-cycle request launched just after an edge, scrambled once released
  task automatic issue(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 req = '{wrEn: w, rdEn: !w, addr: a, data: d};
    @(posedge clk_sys);
    #1 req = '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, data: ~d};
  endtask : issue
  // Normal calibration traffic uses only the defined codes
  task automatic cal(input int idx);
    logic [7:0] codes [4] = '{8'hFF, 8'hAB, 8'h56, 8'hC3};
    issue(1'b1, 8'h0A, codes[idx]);
  endtask : cal
endmodule : mrb_ctl_model
